/* File: hdl/tsm_pkg.sv */
// Purpose: Shared constants for the timer slave-mode trigger controller.
// Assumes: AHB-Lite register access, 32-bit data, one word per register.
// Notes:   Field positions and codes of the slave mode control register.
package tsm_pkg;
  localparam logic [7:0]  ADDR_SMC      = 8'h08;
  localparam logic [7:0]  ADDR_CTL      = 8'h00;
  localparam logic [7:0]  ADDR_STAT     = 8'h04;
  localparam logic [15:0] SMC_RESET     = 16'h0000;
  localparam logic [15:0] CTL_RESET     = 16'h0000;
  localparam int          CTL_RUN_BIT   = 0;
  localparam int          CTL_DIV_LO    = 8;
  localparam int          SMC_REFCLR    = 3;
  localparam int          SMC_MSM       = 7;
  localparam int          SMC_EC2       = 14;
  localparam int          SMC_POL       = 15;
  localparam logic [2:0]  SM_OFF        = 3'h0;
  localparam logic [2:0]  SM_ENC1       = 3'h1;
  localparam logic [2:0]  SM_ENC2       = 3'h2;
  localparam logic [2:0]  SM_ENC3       = 3'h3;
  localparam logic [2:0]  SM_RESET      = 3'h4;
  localparam logic [2:0]  SM_GATED      = 3'h5;
  localparam logic [2:0]  SM_TRIG       = 3'h6;
  localparam logic [2:0]  SM_EXT1       = 3'h7;
  localparam logic [2:0]  TS_CH1ED      = 3'h4;
  localparam logic [2:0]  TS_CH1F       = 3'h5;
  localparam logic [2:0]  TS_CH2F       = 3'h6;
  localparam logic [2:0]  TS_EXT_TRIGGER_FILTERED       = 3'h7;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

/* File: hdl/tsm_slave_ctrl.sv */
// Purpose: Slave-mode trigger selection, external trigger conditioning and
//          counter control of a 16-bit timer, with an AHB-Lite register port.
// Assumes: All trigger and channel inputs are asynchronous; one clock.
// Notes:   Registers: control 0x00, status 0x04, slave mode control 0x08.
`timescale 1ns/1ns

module tsm_slave_ctrl #(
  parameter int CNT_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [3:0]        internal_trigger,
  input  wire logic              ch1_edge_detect,
  input  wire logic              ch1_filtered_input,
  input  wire logic              ch2_filtered_input,
  input  wire logic              ext_trigger_pin,
  input  wire logic              ref_clear_input,
  output logic                   compare_ref_clear,
  output logic                   trigger_input,
  output logic                   master_slave_sync,
  output logic                   update_event,
  output logic [CNT_W-1:0]       counter_value
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]      smc;
    logic [15:0]      ctl;
    logic             run;
    logic [7:0]       ap_addr;
    logic             ap_wr;
    logic             ap_rd;
    logic [31:0]      rdata;
    logic [1:0]       s1_trg;
    logic [1:0]       s2_trg;
    logic [1:0]       s1_c1;
    logic [1:0]       s2_c1;
    logic [1:0]       s1_c2;
    logic [1:0]       s2_c2;
    logic [1:0]       s1_etr;
    logic [1:0]       s2_etr;
    logic [1:0]       s1_clr;
    logic [1:0]       s2_clr;
    logic             etr_prev;
    logic [2:0]       pre_cnt;
    logic             ext_trigger_prescaled;
    logic [1:0]       dts_cnt;
    logic [4:0]       div_cnt;
    logic [3:0]       agree;
    logic             ext_trigger_filtered;
    logic             trigger_input_prev;
    logic             ext_trigger_filtered_prev;
    logic             c1_prev;
    logic             c2_prev;
    logic [CNT_W-1:0] cnt;
    logic             upd;
    logic             clr;
    logic             trigger_input_o;
  } tsm_state_t;

  tsm_state_t s_q;
  tsm_state_t s_d;

  // Filter code to sample divider (in filter-clock ticks) and sample count.
  function automatic logic [4:0] filt_div(input logic [3:0] c);
    unique case (c)
      4'h0, 4'h1, 4'h2, 4'h3: filt_div = 5'h00;
      4'h4, 4'h5:             filt_div = 5'h01;
      4'h6, 4'h7:             filt_div = 5'h03;
      4'h8, 4'h9:             filt_div = 5'h07;
      4'hA, 4'hB, 4'hC:       filt_div = 5'h0F;
      default:                filt_div = 5'h1F;
    endcase
  endfunction

  function automatic logic [3:0] filt_n(input logic [3:0] c);
    unique case (c)
      4'h0:                   filt_n = 4'h1;
      4'h1:                   filt_n = 4'h2;
      4'h2:                   filt_n = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hB: filt_n = 4'h6;
      4'hA, 4'hD:             filt_n = 4'h5;
      default:                filt_n = 4'h8;
    endcase
  endfunction

  localparam logic [2:0] TS_CH1ED_C = tsm_pkg::TS_CH1ED;
  localparam logic [2:0] TS_CH1F_C  = tsm_pkg::TS_CH1F;
  localparam logic [2:0] TS_CH2F_C  = tsm_pkg::TS_CH2F;
  localparam logic [2:0] TS_EXT_TRIGGER_FILTERED_C  = tsm_pkg::TS_EXT_TRIGGER_FILTERED;
  localparam logic [2:0] SM_OFF_C   = tsm_pkg::SM_OFF;
  localparam logic [2:0] SM_ENC1_C  = tsm_pkg::SM_ENC1;
  localparam logic [2:0] SM_ENC2_C  = tsm_pkg::SM_ENC2;
  localparam logic [2:0] SM_ENC3_C  = tsm_pkg::SM_ENC3;
  localparam logic [2:0] SM_RESET_C = tsm_pkg::SM_RESET;
  localparam logic [2:0] SM_GATED_C = tsm_pkg::SM_GATED;
  localparam logic [2:0] SM_TRIG_C  = tsm_pkg::SM_TRIG;
  localparam logic [2:0] SM_EXT1_C  = tsm_pkg::SM_EXT1;
  localparam int         SMC_REFCLR = tsm_pkg::SMC_REFCLR;
  localparam int         SMC_EC2    = tsm_pkg::SMC_EC2;
  localparam int         SMC_POL    = tsm_pkg::SMC_POL;
  localparam int         SMC_MSM    = tsm_pkg::SMC_MSM;
  localparam int         CTL_RUN_BIT = tsm_pkg::CTL_RUN_BIT;
  localparam int         CTL_DIV_LO = tsm_pkg::CTL_DIV_LO;

  logic       clk_trg;
  logic       etr_lvl;
  logic       trg_rise;
  logic       ext_trigger_filtered_rise;
  logic       c1_edge;
  logic       c2_edge;
  logic       cnt_step;
  logic       cnt_up;
  logic       dts_tick;
  logic [1:0] pre_sel;
  logic [2:0] sm;
  logic [2:0] ts;

  always_comb begin
    s_d       = s_q;
    sm        = s_q.smc[2:0];
    ts        = s_q.smc[6:4];
    cnt_step  = 1'b0;
    cnt_up    = 1'b1;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    unique case (ts)
      TS_CH1ED_C: clk_trg = ch1_edge_detect;
      TS_CH1F_C:  clk_trg = ch1_filtered_input;
      TS_CH2F_C:  clk_trg = ch2_filtered_input;
      TS_EXT_TRIGGER_FILTERED_C:  clk_trg = 1'b0;
      default:    clk_trg = internal_trigger[ts[1:0]];
    endcase
    s_d.s1_trg = {s_q.s1_trg[0], clk_trg};
    s_d.s2_trg = {s_q.s2_trg[0], s_q.s1_trg[1]};
    s_d.s1_c1  = {s_q.s1_c1[0], ch1_filtered_input};
    s_d.s2_c1  = {s_q.s2_c1[0], s_q.s1_c1[1]};
    s_d.s1_c2  = {s_q.s1_c2[0], ch2_filtered_input};
    s_d.s2_c2  = {s_q.s2_c2[0], s_q.s1_c2[1]};
    s_d.s1_etr = {s_q.s1_etr[0], ext_trigger_pin};
    s_d.s2_etr = {s_q.s2_etr[0], s_q.s1_etr[1]};
    s_d.s1_clr = {s_q.s1_clr[0], ref_clear_input};
    s_d.s2_clr = {s_q.s2_clr[0], s_q.s1_clr[1]};

    // ----------------------------------------------------------------
    // External trigger prescaler and filter
    // ----------------------------------------------------------------
    pre_sel = s_q.smc[13:12];
    etr_lvl = s_q.s2_etr[1] ^ s_q.smc[SMC_POL];
    s_d.etr_prev = etr_lvl;
    if (etr_lvl && !s_q.etr_prev) begin
      s_d.pre_cnt = s_q.pre_cnt + 3'h1;
    end
    unique case (pre_sel)
      2'h0:    s_d.ext_trigger_prescaled = etr_lvl;
      2'h1:    s_d.ext_trigger_prescaled = s_q.pre_cnt[0];
      2'h2:    s_d.ext_trigger_prescaled = s_q.pre_cnt[1];
      default: s_d.ext_trigger_prescaled = s_q.pre_cnt[2];
    endcase

    dts_tick = 1'b0;
    if (s_q.dts_cnt >= (2'h1 << s_q.ctl[CTL_DIV_LO +: 2]) - 2'h1
        || s_q.ctl[CTL_DIV_LO +: 2] == 2'h3) begin
      s_d.dts_cnt = 2'h0;
      dts_tick    = 1'b1;
    end else begin
      s_d.dts_cnt = s_q.dts_cnt + 2'h1;
    end
    if (dts_tick) begin
      if (s_q.div_cnt >= filt_div(s_q.smc[11:8])) begin
        s_d.div_cnt = 5'h00;
        if (s_q.ext_trigger_prescaled == s_q.ext_trigger_filtered) begin
          s_d.agree = 4'h0;
        end else if (s_q.agree + 4'h1 >= filt_n(s_q.smc[11:8])) begin
          s_d.agree = 4'h0;
          s_d.ext_trigger_filtered  = s_q.ext_trigger_prescaled;
        end else begin
          s_d.agree = s_q.agree + 4'h1;
        end
      end else begin
        s_d.div_cnt = s_q.div_cnt + 5'h01;
      end
    end

    // ----------------------------------------------------------------
    // Trigger selection and slave modes
    // ----------------------------------------------------------------
    s_d.trigger_input_o = (ts == TS_EXT_TRIGGER_FILTERED_C) ? s_q.ext_trigger_filtered : s_q.s2_trg[1];
    s_d.trigger_input_prev = s_q.trigger_input_o;
    s_d.ext_trigger_filtered_prev = s_q.ext_trigger_filtered;
    s_d.c1_prev   = s_q.s2_c1[1];
    s_d.c2_prev   = s_q.s2_c2[1];
    trg_rise  = s_q.trigger_input_o && !s_q.trigger_input_prev;
    ext_trigger_filtered_rise = s_q.ext_trigger_filtered && !s_q.ext_trigger_filtered_prev;
    c1_edge   = s_q.s2_c1[1] ^ s_q.c1_prev;
    c2_edge   = s_q.s2_c2[1] ^ s_q.c2_prev;
    s_d.upd   = 1'b0;
    s_d.clr   = s_q.smc[SMC_REFCLR] ? s_q.ext_trigger_filtered : s_q.s2_clr[1];
    s_d.run   = s_q.ctl[CTL_RUN_BIT];

    unique case (sm)
      SM_OFF_C:   cnt_step = s_q.run;
      SM_ENC1_C: begin
        cnt_step = s_q.run && c2_edge;
        cnt_up   = s_q.s2_c2[1] ^ s_q.s2_c1[1];
      end
      SM_ENC2_C: begin
        cnt_step = s_q.run && c1_edge;
        cnt_up   = s_q.s2_c1[1] ~^ s_q.s2_c2[1];
      end
      SM_ENC3_C: begin
        cnt_step = s_q.run && (c1_edge || c2_edge);
        cnt_up   = c1_edge ? (s_q.s2_c1[1] ~^ s_q.s2_c2[1])
                           : (s_q.s2_c2[1] ^ s_q.s2_c1[1]);
      end
      SM_RESET_C: begin
        cnt_step = s_q.run;
        if (trg_rise) begin
          s_d.upd  = 1'b1;
          cnt_step = 1'b0;
        end
      end
      SM_GATED_C: cnt_step = s_q.run && s_q.trigger_input_o;
      SM_TRIG_C: begin
        if (trg_rise) begin
          s_d.ctl[CTL_RUN_BIT] = 1'b1;
        end
        cnt_step = s_q.run;
      end
      default:    cnt_step = s_q.run && (s_q.smc[SMC_EC2] ? ext_trigger_filtered_rise
                                                          : trg_rise);
    endcase
    if (s_q.smc[SMC_EC2] && sm != SM_EXT1_C
        && (sm == SM_OFF_C || sm > SM_ENC3_C)) begin
      cnt_step = s_q.run && ext_trigger_filtered_rise && (sm != SM_GATED_C || s_q.trigger_input_o);
    end

    if (s_d.upd) begin
      s_d.cnt = '0;
    end else if (cnt_step) begin
      s_d.cnt = cnt_up ? s_q.cnt + 1'b1 : s_q.cnt - 1'b1;
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    s_d.ap_wr = 1'b0;
    s_d.ap_rd = 1'b0;
    if (hsel && hready && htrans == tsm_pkg::HTRANS_NONSEQ) begin
      s_d.ap_addr = haddr[7:0];
      s_d.ap_wr   = hwrite;
      s_d.ap_rd   = !hwrite;
    end
    if (s_q.ap_wr) begin
      if (s_q.ap_addr == tsm_pkg::ADDR_SMC) begin
        s_d.smc = hwdata[15:0];
      end else if (s_q.ap_addr == tsm_pkg::ADDR_CTL) begin
        s_d.ctl = hwdata[15:0];
      end
    end
    s_d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans == tsm_pkg::HTRANS_NONSEQ && !hwrite) begin
      unique case (haddr[7:0])
        tsm_pkg::ADDR_SMC:  s_d.rdata = {16'h0000, s_d.smc};
        tsm_pkg::ADDR_CTL:  s_d.rdata = {16'h0000, s_d.ctl};
        tsm_pkg::ADDR_STAT: s_d.rdata = {{(32-CNT_W){1'b0}}, s_q.cnt};
        default:            s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q     <= '0;
      s_q.smc <= tsm_pkg::SMC_RESET;
      s_q.ctl <= tsm_pkg::CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata            = s_q.rdata;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign compare_ref_clear = s_q.clr;
  assign trigger_input     = s_q.trigger_input_o;
  assign master_slave_sync = s_q.smc[SMC_MSM];
  assign update_event      = s_q.upd;
  assign counter_value     = s_q.cnt;

endmodule // tsm_slave_ctrl

/* File: bench/tsm_trig_partner.sv */
// Purpose: Model of neighbour timer triggers and the external trigger pin.
// Assumes: Sources are registered on the shared clock.
// Notes:   Each level is held for several clocks by the bench.
`timescale 1ns/1ns
module tsm_trig_partner (
  input  wire logic       sys_clk,
  input  wire logic [3:0] trig_req,
  input  wire logic       etr_req,
  output logic      [3:0] internal_trigger,
  output logic            ext_trigger_pin
);
  // Registered outputs change at most once a clock, never faster.
  always_ff @(posedge sys_clk) begin
    internal_trigger <= trig_req;
    ext_trigger_pin  <= etr_req;
  end
endmodule // tsm_trig_partner

/* File: bench/tsm_slave_ctrl_assertions.sv */
// Purpose: Port checks of the slave-mode trigger controller.
// Assumes: Register shadows follow completed bus writes.
// Notes:   Bound from the bench top.
`timescale 1ns/1ns
module tsm_slave_ctrl_assertions #(
  parameter int CNT_W = 16
) (
  input wire logic             sys_clk,
  input wire logic             sys_rst,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic [3:0]       internal_trigger,
  input wire logic             ext_trigger_pin,
  input wire logic             ref_clear_input,
  input wire logic             compare_ref_clear,
  input wire logic             trigger_input,
  input wire logic             master_slave_sync,
  input wire logic             update_event,
  input wire logic [CNT_W-1:0] counter_value
);
  logic [15:0] smc_q, ctl_q;
  logic [7:0]  adr_q;
  logic        wph_q;
  always_ff @(posedge sys_clk) begin
    adr_q <= haddr[7:0];
    if (sys_rst) begin
      smc_q <= tsm_pkg::SMC_RESET;
      ctl_q <= tsm_pkg::CTL_RESET;
      wph_q <= 1'b0;
    end else begin
      wph_q <= hsel && hready && htrans == tsm_pkg::HTRANS_NONSEQ && hwrite;
      if (wph_q && adr_q == tsm_pkg::ADDR_SMC)
        smc_q <= hwdata[15:0];
      if (wph_q && adr_q == tsm_pkg::ADDR_CTL)
        ctl_q <= hwdata[15:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sync_bit_a: assert property (master_slave_sync == smc_q[7])
    else $error("sync output wrong");
  free_run_a: assert property ((smc_q[2:0] == 3'h0 && !smc_q[14] && ctl_q[0])[*2]
    |=> counter_value == $past(counter_value) + 1'b1) else $error("free count wrong");
  upd_pulse_a: assert property (update_event
    |-> $past(smc_q[2:0]) == tsm_pkg::SM_RESET ##1 !update_event) else $error("update wrong");
  gate_hold_a: assert property ((smc_q[2:0] == 3'h5 && !trigger_input)[*4]
    |=> $stable(counter_value)) else $error("gated count moved");
  ext_step_a: assert property (smc_q[2:0] == 3'h7 && $stable(smc_q)
    && counter_value != $past(counter_value) |-> counter_value == $past(counter_value) + 1'b1)
    else $error("external step wrong");
  ref_clr_a: assert property ((!smc_q[3] && $stable(ref_clear_input))[*5]
    |-> compare_ref_clear == ref_clear_input) else $error("clear source wrong");
  trig_sel_a: assert property ((!smc_q[6] && $stable(internal_trigger) && $stable(smc_q))[*6]
    |-> trigger_input == internal_trigger[smc_q[5:4]]) else $error("trigger select wrong");
  etr_pol_a: assert property ((smc_q[6:4] == 3'h7 && smc_q[13:8] == 6'h00 && ctl_q[9:8] == 2'h0
    && $stable(ext_trigger_pin) && $stable(smc_q))[*8]
    |-> trigger_input == (ext_trigger_pin ^ smc_q[15])) else $error("polarity wrong");
endmodule // tsm_slave_ctrl_assertions

/* File: bench/tsm_slave_ctrl_tb_top.sv */
// Purpose: Self-checking bench of the slave-mode trigger controller.
// Assumes: Zero-wait slave; the counter counts up from zero.
// Notes:   Read data is checked by a monitor against a queue.
`timescale 1ns/1ns
module tsm_slave_ctrl_tb_top;
  logic        sys_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, dph_q;
  logic [31:0] haddr, hwdata, hrdata, q[$];
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  src;
  logic [3:0]  internal_trigger;
  logic        ext_trigger_pin, ref_clear_input, compare_ref_clear, trigger_input;
  logic        master_slave_sync, update_event;
  logic [15:0] counter_value, rnd, c, smc;
  wire         ch1_edge_detect = src[4];
  wire         ch1_filtered_input = src[5];
  wire         ch2_filtered_input = src[6];
  int          mismatches, check_count;
  assign hready = hreadyout;
  tsm_slave_ctrl tsm_slave_ctrl_inst (
    .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .internal_trigger, .ch1_edge_detect, .ch1_filtered_input,
    .ch2_filtered_input, .ext_trigger_pin, .ref_clear_input, .compare_ref_clear,
    .trigger_input, .master_slave_sync, .update_event, .counter_value);
  tsm_trig_partner tsm_trig_partner_inst (.sys_clk, .trig_req(src[3:0]), .etr_req(src[7]),
    .internal_trigger, .ext_trigger_pin);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge sys_clk);
    rnd = lfsr(rnd);
    haddr <= {24'h000000, a};
    htrans <= tsm_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {rnd, d};
    do @(posedge sys_clk); while (hready !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    q.push_back({16'h0000, e});
    bus(a, 1'b0, 16'h0000);
  endtask
  task automatic setm(input logic [15:0] v);
    wr(tsm_pkg::ADDR_SMC, smc & 16'hFFF8);
    wr(tsm_pkg::ADDR_SMC, v & 16'hFFF8);
    wr(tsm_pkg::ADDR_SMC, v);
    smc = v;
  endtask
  task automatic drv(input int b, input logic v);
    @(posedge sys_clk);
    src[b] <= v;
    cyc(10);
    @(negedge sys_clk);
  endtask
  task automatic tog(input int b, input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge sys_clk);
      src[b] <= !src[b];
      cyc(hi);
      src[b] <= !src[b];
      cyc(lo);
    end
  endtask
  task automatic clr;
    setm(16'h0004);
    tog(0, 1, 3, 8);
    rd(tsm_pkg::ADDR_STAT, 16'h0000);
  endtask
  always @(posedge sys_clk) begin
    if (dph_q && hready === 1'b1) begin
      chk("hrdata", hrdata, q.pop_front());
      chk("hresp", {31'h0, hresp}, 32'h0);
    end
    if (hready === 1'b1)
      dph_q <= hsel && htrans == tsm_pkg::HTRANS_NONSEQ && !hwrite;
  end
  initial begin
    ref_clear_input = 1'b0;
    forever begin
      cyc(8);
      ref_clear_input <= rnd[3];
    end
  end
  initial begin
    cyc(20000);
    mismatches++;
    end_of_test();
  end
  initial begin
    {sys_rst, hsel, hsize} = 5'h1A;
    {hwrite, htrans, haddr, hwdata, dph_q} = '0;
    {src, smc} = '0;
    rnd = 16'h5DD3;
    cyc(3);
    sys_rst <= 1'b0;
    rd(tsm_pkg::ADDR_SMC, tsm_pkg::SMC_RESET);
    rd(tsm_pkg::ADDR_CTL, tsm_pkg::CTL_RESET);
    c = rnd & 16'hBFFF;
    setm(c);
    rd(tsm_pkg::ADDR_SMC, c);
    wr(8'h0C, rnd);
    rd(8'h0C, 16'h0000);
    setm(16'h0000);
    wr(tsm_pkg::ADDR_CTL, 16'h0001);
    cyc(2);
    @(negedge sys_clk);
    c = counter_value;
    repeat (10) @(negedge sys_clk);
    chk("count", 16'(counter_value - c), 32'h0000000A);
    wr(tsm_pkg::ADDR_CTL, 16'h0000);
    for (int s = 0; s < 8; s++) begin
      setm(16'(s << 4));
      drv(s, 1'b1);
      chk("trigger", trigger_input, 32'h1);
      drv(s, 1'b0);
      chk("trigger", trigger_input, 32'h0);
    end
    for (int m = 1; m < 4; m++) begin
      clr();
      setm(16'(m));
      wr(tsm_pkg::ADDR_CTL, 16'h0001);
      drv(6, 1'b1);
      drv(5, 1'b1);
      c = (m == 3) ? 16'h0002 : 16'h0001;
      chk("encoder", counter_value == c || counter_value == -c, 32'h1);
      wr(tsm_pkg::ADDR_CTL, 16'h0000);
      setm(16'h0000);
      src[6:5] <= 2'h0;
    end
    clr();
    setm(16'h0025);
    wr(tsm_pkg::ADDR_CTL, 16'h0001);
    tog(2, 2, 20, 10);
    rd(tsm_pkg::ADDR_STAT, 16'h0028);
    wr(tsm_pkg::ADDR_CTL, 16'h0000);
    clr();
    setm(16'h0036);
    tog(3, 1, 3, 8);
    rd(tsm_pkg::ADDR_CTL, 16'h0001);
    wr(tsm_pkg::ADDR_CTL, 16'h0000);
    clr();
    setm(16'h0017);
    wr(tsm_pkg::ADDR_CTL, 16'h0001);
    tog(1, 5, 3, 3);
    cyc(8);
    rd(tsm_pkg::ADDR_STAT, 16'h0005);
    wr(tsm_pkg::ADDR_CTL, 16'h0000);
    drv(7, 1'b1);
    clr();
    setm(16'hC080);
    wr(tsm_pkg::ADDR_CTL, 16'h0001);
    tog(7, 3, 4, 4);
    cyc(8);
    rd(tsm_pkg::ADDR_STAT, 16'h0003);
    chk("sync", master_slave_sync, 32'h1);
    wr(tsm_pkg::ADDR_CTL, 16'h0000);
    drv(7, 1'b0);
    clr();
    setm(16'h4377);
    wr(tsm_pkg::ADDR_CTL, 16'h0001);
    tog(7, 2, 12, 12);
    tog(7, 2, 3, 12);
    rd(tsm_pkg::ADDR_STAT, 16'h0002);
    end_of_test();
  end
endmodule // tsm_slave_ctrl_tb_top
bind tsm_slave_ctrl tsm_slave_ctrl_assertions #(.CNT_W(CNT_W)) tsm_slave_ctrl_assertions_inst (
  .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .internal_trigger,
  .ext_trigger_pin, .ref_clear_input, .compare_ref_clear, .trigger_input, .master_slave_sync,
  .update_event, .counter_value);
